// ===== user_break_unit.sv
// Two-channel user break matcher with branch trace queue
//Behaviour
//- A channel never matches when its request, kind or read/write select group is 00.
//- Satisfied conditions raise a break request and report the break type.
//- A match sets the channel's CPU or DMA match flag.
//- Match flags stay set until software writes 0.
//- Near-simultaneous data and fetch breaks produce only one request.
//- Per-channel bit selects pre- or post-execution for fetch breaks.
//- Fetch breaks only for instructions that really execute.
//- Delay-slot pre-break fires at the next instruction accepting a break.
//- Channel B fetch conditions ignore break data and data mask.
//- Data access address compare width follows access size.
//- Data-qualified channel B needs address and data match together.
//- Word and byte data compares ignore upper sixteen data bits.
//- Sequential mode breaks only on B matching after an earlier A.
//- With counting, B breaks when the execution count equals one.
//- Pre-execution break suppresses the instruction and saves its address.
//- Post-execution and address-only breaks save the next instruction address.
//- Address-plus-data breaks save the next unexecuted instruction start.
//- With trace on, each branch pushes a source and destination pair.
//- Source entry keeps address and pointer to compute the source.
//- Eight pairs share one read pointer, advanced after destination read.
//- Trace re-enable invalidates entries and restarts the write pointer.
//- Each entry valid flag sets on capture, clears on read or reset.
//- Source pointer is a three-bit instruction buffer number.
`timescale 1ns/1ps
module user_break_unit #(
	parameter int TRACE_DEPTH = 8
) (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic [7:0] reg_addr,
	input wire logic [31:0] reg_wdata,
	input wire logic reg_wr,
	input wire logic reg_rd,
	output logic [31:0] reg_rdata,
	input wire break_pkg::bus_cycle_s bus_cyc,
	input wire break_pkg::exec_slot_s exec_slot,
	input wire break_pkg::branch_rec_s branch_rec,
	input wire logic break_ack,
	output logic break_req,
	output logic [1:0] break_type,
	output logic [31:0] saved_pc,
	output logic suppress_exec
);
	import break_pkg::*;

	localparam int PW = $clog2(TRACE_DEPTH);

	// Queue pointers wrap naturally, so the depth must be a power of two
	if (TRACE_DEPTH < 2 || (TRACE_DEPTH & (TRACE_DEPTH - 1)) != 0) begin : g_bad_depth
		$error("TRACE_DEPTH must be a power of two of at least 2");
	end

	// Condition match for one channel against one cycle
	function automatic logic chan_hit(input cycle_sel_s sel, input logic [31:0] bar, input logic [31:0] bam,
			input logic [7:0] basid, input logic is_fetch, input logic is_dma, input logic is_write,
			input logic [1:0] size, input logic [31:0] addr, input logic [7:0] address_space_id);
		logic req_ok;
		logic kind_ok;
		logic rw_ok;
		logic size_ok;
		logic [31:0] low;
		req_ok = is_dma ? sel.req[1] : sel.req[0];
		kind_ok = is_fetch ? sel.kind[0] : sel.kind[1];
		rw_ok = is_write ? sel.rw[1] : sel.rw[0];
		size_ok = is_fetch ? (sel.size != SZ_BYTE) : ((sel.size == SZ_ANY) || (sel.size == size));
		low = 32'h0000_0000;
		if (!is_fetch && size == SZ_LONG)
			low = 32'h0000_0003;
		else if (!is_fetch && size == SZ_WORD)
			low = 32'h0000_0001;
		chan_hit = req_ok && kind_ok && rw_ok && size_ok
			&& (((bar ^ addr) & ~(bam | low)) == 32'h0000_0000)
			&& (!sel.address_space_id_en || address_space_id == basid);
	endfunction : chan_hit

	// Masked data compare for channel B
	function automatic logic data_hit(input logic [1:0] size, input logic [31:0] bd, input logic [31:0] bdm,
			input logic [31:0] data);
		logic [31:0] span;
		span = (size == SZ_LONG || size == SZ_ANY) ? 32'hFFFF_FFFF : 32'h0000_FFFF;
		data_hit = ((bd ^ data) & ~bdm & span) == 32'h0000_0000;
	endfunction : data_hit

	logic [31:0] a_addr_reg, a_mask_reg, b_addr_reg, b_mask_reg, b_data_reg, b_dmask_reg;
	logic [7:0] a_address_space_id_reg, b_address_space_id_reg;
	cycle_sel_s a_sel_reg, b_sel_reg;
	logic [15:0] ctrl_reg, count_reg;
	logic seq_armed_reg, pending_reg, break_req_reg;
	logic [1:0] pending_type_reg, break_type_reg;
	logic [31:0] saved_pc_reg, reg_rdata_reg, rdata_next;
	logic [31:0] src_mem [TRACE_DEPTH];
	logic [27:0] dst_mem [TRACE_DEPTH];
	logic [TRACE_DEPTH-1:0] svf_reg, dvf_reg;
	logic [PW-1:0] wr_ptr_reg, rd_ptr_reg;

	logic wr_ctrl, rd_src, rd_dst, trace_restart, push;
	logic a_fetch, a_data, b_fetch, b_data, a_hit, b_hit;
	logic count_ok, a_sat, b_sat, pre_trig, post_trig, fire;
	logic [1:0] defer_type;

	assign wr_ctrl = reg_wr && reg_addr == OFF_CTRL;
	assign rd_src = reg_rd && reg_addr == OFF_TSRC;
	assign rd_dst = reg_rd && reg_addr == OFF_TDST;
	assign trace_restart = wr_ctrl && reg_wdata[CTL_TRACE] && !ctrl_reg[CTL_TRACE];
	assign push = ctrl_reg[CTL_TRACE] && branch_rec.valid && !trace_restart;

	// Raw channel matches; fetch matches come from executing instructions only
	assign a_fetch = exec_slot.valid && chan_hit(a_sel_reg, a_addr_reg, a_mask_reg, a_address_space_id_reg, 1'b1, 1'b0,
		1'b0, SZ_WORD, exec_slot.addr, exec_slot.address_space_id);
	assign a_data = bus_cyc.valid && chan_hit(a_sel_reg, a_addr_reg, a_mask_reg, a_address_space_id_reg, 1'b0,
		bus_cyc.is_dma, bus_cyc.is_write, bus_cyc.size, bus_cyc.addr, bus_cyc.address_space_id);
	assign b_fetch = exec_slot.valid && chan_hit(b_sel_reg, b_addr_reg, b_mask_reg, b_address_space_id_reg, 1'b1, 1'b0,
		1'b0, SZ_WORD, exec_slot.addr, exec_slot.address_space_id);
	assign b_data = bus_cyc.valid && chan_hit(b_sel_reg, b_addr_reg, b_mask_reg, b_address_space_id_reg, 1'b0,
		bus_cyc.is_dma, bus_cyc.is_write, bus_cyc.size, bus_cyc.addr, bus_cyc.address_space_id)
		&& (!ctrl_reg[CTL_DATA_EN] || data_hit(bus_cyc.size, b_data_reg, b_dmask_reg, bus_cyc.data));
	assign a_hit = a_fetch || a_data;
	assign b_hit = b_fetch || b_data;

	// Sequential and execution count qualification
	assign count_ok = !ctrl_reg[CTL_COUNT_EN] || count_reg == COUNT_LAST;
	assign a_sat = a_hit && !ctrl_reg[CTL_SEQ];
	assign b_sat = b_hit && count_ok && (!ctrl_reg[CTL_SEQ] || seq_armed_reg);

	// Pre-execution triggers fire on this slot; everything else waits
	assign pre_trig = (a_sat && a_fetch && !ctrl_reg[CTL_POST_A]) || (b_sat && b_fetch && !ctrl_reg[CTL_POST_B]);
	assign post_trig = (a_sat || b_sat) && !pre_trig;
	assign fire = !break_req_reg && exec_slot.valid && exec_slot.accept && (pre_trig || pending_reg);
	assign defer_type = ((a_sat && a_data) || (b_sat && b_data)) ? BT_DATA
		: (pre_trig ? BT_FETCH_PRE : BT_FETCH_POST);

	// Channel A and B condition registers
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			a_addr_reg <= 32'h0000_0000;
			a_mask_reg <= 32'h0000_0000;
			a_address_space_id_reg <= 8'h00;
			a_sel_reg <= SEL_RESET;
			b_addr_reg <= 32'h0000_0000;
			b_mask_reg <= 32'h0000_0000;
			b_address_space_id_reg <= 8'h00;
			b_sel_reg <= SEL_RESET;
			b_data_reg <= 32'h0000_0000;
			b_dmask_reg <= 32'h0000_0000;
		end else if (reg_wr) begin
			unique case (reg_addr)
				OFF_A_ADDR: a_addr_reg <= reg_wdata;
				OFF_A_MASK: a_mask_reg <= reg_wdata;
				OFF_A_ADDRESS_SPACE_ID: a_address_space_id_reg <= reg_wdata[7:0];
				OFF_A_SEL: a_sel_reg <= reg_wdata[15:0];
				OFF_B_ADDR: b_addr_reg <= reg_wdata;
				OFF_B_MASK: b_mask_reg <= reg_wdata;
				OFF_B_ADDRESS_SPACE_ID: b_address_space_id_reg <= reg_wdata[7:0];
				OFF_B_SEL: b_sel_reg <= reg_wdata[15:0];
				OFF_B_DATA: b_data_reg <= reg_wdata;
				OFF_B_DMASK: b_dmask_reg <= reg_wdata;
				default: ;
			endcase
		end
	end

	// Control bits and sticky match flags; a new match beats a clearing write
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			ctrl_reg <= CTL_RESET;
		end else begin
			if (wr_ctrl) begin
				ctrl_reg[5:0] <= reg_wdata[5:0];
				ctrl_reg[11:8] <= ctrl_reg[11:8] & reg_wdata[11:8];
			end
			if (a_fetch || (a_data && !bus_cyc.is_dma))
				ctrl_reg[CTL_CPU_FLAG_A] <= 1'b1;
			if (a_data && bus_cyc.is_dma)
				ctrl_reg[CTL_DMA_FLAG_A] <= 1'b1;
			if (b_fetch || (b_data && !bus_cyc.is_dma))
				ctrl_reg[CTL_CPU_FLAG_B] <= 1'b1;
			if (b_data && bus_cyc.is_dma)
				ctrl_reg[CTL_DMA_FLAG_B] <= 1'b1;
		end
	end

	// Execution count decrements on qualified B matches until it reaches one
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			count_reg <= COUNT_RESET;
		end else if (reg_wr && reg_addr == OFF_COUNT) begin
			count_reg <= reg_wdata[15:0];
		end else if (b_hit && !count_ok && (!ctrl_reg[CTL_SEQ] || seq_armed_reg)) begin
			count_reg <= count_reg - COUNT_LAST;
		end
	end

	// Sequential arming by channel A; armed state is only seen next cycle
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			seq_armed_reg <= 1'b0;
		end else if (!ctrl_reg[CTL_SEQ] || b_sat) begin
			seq_armed_reg <= 1'b0;
		end else if (a_hit) begin
			seq_armed_reg <= 1'b1;
		end
	end

	// Deferred break waits for the next instruction that accepts a break
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			pending_reg <= 1'b0;
			pending_type_reg <= BT_NONE;
		end else if (fire || break_req_reg) begin
			pending_reg <= 1'b0;
		end else if (post_trig || (pre_trig && !(exec_slot.valid && exec_slot.accept))) begin
			pending_reg <= 1'b1;
			if (!pending_reg)
				pending_type_reg <= defer_type;
		end
	end

	// One request to the interrupt controller, held until acknowledged
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			break_req_reg <= 1'b0;
			break_type_reg <= BT_NONE;
			saved_pc_reg <= 32'h0000_0000;
		end else if (fire) begin
			break_req_reg <= 1'b1;
			break_type_reg <= pending_reg ? pending_type_reg : BT_FETCH_PRE;
			saved_pc_reg <= exec_slot.addr;
		end else if (break_ack) begin
			break_req_reg <= 1'b0;
		end
	end

	assign break_req = break_req_reg;
	assign break_type = break_type_reg;
	assign saved_pc = saved_pc_reg;
	assign suppress_exec = fire;

	// Trace storage; contents are not reset, only the valid flags
	always_ff @(posedge sys_clk) begin
		if (push) begin
			src_mem[wr_ptr_reg] <= {1'b0, branch_rec.decode_buffer_pointer, branch_rec.src};
			dst_mem[wr_ptr_reg] <= branch_rec.dest;
		end
	end

	// Trace valid flags and pointers; capture wins over a read clear
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			svf_reg <= '0;
			dvf_reg <= '0;
			wr_ptr_reg <= '0;
			rd_ptr_reg <= '0;
		end else if (trace_restart) begin
			svf_reg <= '0;
			dvf_reg <= '0;
			wr_ptr_reg <= '0;
		end else begin
			if (rd_src)
				svf_reg[rd_ptr_reg] <= 1'b0;
			if (rd_dst) begin
				dvf_reg[rd_ptr_reg] <= 1'b0;
				rd_ptr_reg <= rd_ptr_reg + 1'b1;
			end
			if (push) begin
				svf_reg[wr_ptr_reg] <= 1'b1;
				dvf_reg[wr_ptr_reg] <= 1'b1;
				wr_ptr_reg <= wr_ptr_reg + 1'b1;
			end
		end
	end

	// Read data selection; unmapped offsets read zero
	always_comb begin
		rdata_next = 32'h0000_0000;
		unique case (reg_addr)
			OFF_A_ADDR: rdata_next = a_addr_reg;
			OFF_A_MASK: rdata_next = a_mask_reg;
			OFF_A_ADDRESS_SPACE_ID: rdata_next = {24'h00_0000, a_address_space_id_reg};
			OFF_A_SEL: rdata_next = {16'h0000, a_sel_reg};
			OFF_B_ADDR: rdata_next = b_addr_reg;
			OFF_B_MASK: rdata_next = b_mask_reg;
			OFF_B_ADDRESS_SPACE_ID: rdata_next = {24'h00_0000, b_address_space_id_reg};
			OFF_B_SEL: rdata_next = {16'h0000, b_sel_reg};
			OFF_B_DATA: rdata_next = b_data_reg;
			OFF_B_DMASK: rdata_next = b_dmask_reg;
			OFF_CTRL: rdata_next = {16'h0000, ctrl_reg};
			OFF_COUNT: rdata_next = {16'h0000, count_reg};
			OFF_TSRC: rdata_next = {svf_reg[rd_ptr_reg], src_mem[rd_ptr_reg][30:0]};
			OFF_TDST: rdata_next = {dvf_reg[rd_ptr_reg], 3'h0, dst_mem[rd_ptr_reg]};
			default: rdata_next = 32'h0000_0000;
		endcase
	end

	// Read data stand one cycle after the strobe
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst)
			reg_rdata_reg <= 32'h0000_0000;
		else if (reg_rd)
			reg_rdata_reg <= rdata_next;
	end

	assign reg_rdata = reg_rdata_reg;

	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (rst);

	// Zero select group on channel A blocks every match
	property p_zero_group;
		(a_sel_reg.req == 2'h0 || a_sel_reg.kind == 2'h0 || a_sel_reg.rw == 2'h0) |-> !a_hit;
	endproperty
	a_zero_group: assert property (p_zero_group) else $error("channel A matched with a zero select group");

	// A firing slot raises the request with a type
	property p_request;
		fire |=> break_req && break_type != BT_NONE;
	endproperty
	a_request: assert property (p_request) else $error("break fired without a typed request");

	// CPU fetch match on A shows in the flag next cycle
	property p_flag_set;
		a_fetch |=> ctrl_reg[CTL_CPU_FLAG_A];
	endproperty
	a_flag_set: assert property (p_flag_set) else $error("channel A CPU flag not set on match");

	// Flag holds unless software writes 0 to it
	property p_flag_sticky;
		ctrl_reg[CTL_DMA_FLAG_B] && !(wr_ctrl && !reg_wdata[CTL_DMA_FLAG_B]) |=> ctrl_reg[CTL_DMA_FLAG_B];
	endproperty
	a_flag_sticky: assert property (p_flag_sticky) else $error("match flag lost without a clearing write");

	// No second request while one is outstanding
	property p_single;
		break_req_reg && !break_ack |=> break_req_reg && $stable(saved_pc_reg);
	endproperty
	a_single: assert property (p_single) else $error("outstanding request disturbed");

	// Pre-execution break: suppress the slot, then save its address
	sequence s_pre_hit;
		exec_slot.valid && exec_slot.accept && pre_trig && !break_req_reg && !pending_reg;
	endsequence
	sequence s_pre_saved;
		break_req && saved_pc == $past(exec_slot.addr) && break_type == BT_FETCH_PRE;
	endsequence
	property p_pre_exec;
		s_pre_hit |-> suppress_exec ##1 s_pre_saved;
	endproperty
	a_pre_exec: assert property (p_pre_exec) else $error("pre-execution break not taken on its slot");

	// Sequential mode ignores B before A has armed
	property p_seq_order;
		ctrl_reg[CTL_SEQ] && !seq_armed_reg |-> !b_sat;
	endproperty
	a_seq_order: assert property (p_seq_order) else $error("sequential break without earlier A match");

	// Counting mode holds off B until the count reaches one
	property p_count;
		ctrl_reg[CTL_COUNT_EN] && count_reg > COUNT_LAST |-> !b_sat;
	endproperty
	a_count: assert property (p_count) else $error("count break before count reached one");

	// Captured pair is valid after push
	property p_push;
		push && !rd_dst |=> svf_reg[$past(wr_ptr_reg)] && dvf_reg[$past(wr_ptr_reg)];
	endproperty
	a_push: assert property (p_push) else $error("trace entry not marked valid after capture");

	// Queue advances only on a destination read
	property p_advance;
		!trace_restart |=> (rd_ptr_reg != $past(rd_ptr_reg)) == $past(rd_dst);
	endproperty
	a_advance: assert property (p_advance) else $error("read pointer moved without destination read");
endmodule : user_break_unit

// ===== break_pkg.sv
// Shared constants, field layouts and carriers for the user break unit
package break_pkg;
	// Register offsets (byte addresses on the register port)
	localparam logic [7:0] OFF_A_ADDR = 8'h00;
	localparam logic [7:0] OFF_A_MASK = 8'h04;
	localparam logic [7:0] OFF_A_ADDRESS_SPACE_ID = 8'h08;
	localparam logic [7:0] OFF_A_SEL = 8'h0C;
	localparam logic [7:0] OFF_B_ADDR = 8'h10;
	localparam logic [7:0] OFF_B_MASK = 8'h14;
	localparam logic [7:0] OFF_B_ADDRESS_SPACE_ID = 8'h18;
	localparam logic [7:0] OFF_B_SEL = 8'h1C;
	localparam logic [7:0] OFF_B_DATA = 8'h20;
	localparam logic [7:0] OFF_B_DMASK = 8'h24;
	localparam logic [7:0] OFF_CTRL = 8'h28;
	localparam logic [7:0] OFF_COUNT = 8'h2C;
	localparam logic [7:0] OFF_TSRC = 8'h30;
	localparam logic [7:0] OFF_TDST = 8'h34;

	// Break control bit positions
	localparam int CTL_COUNT_EN = 0;
	localparam int CTL_DATA_EN = 1;
	localparam int CTL_SEQ = 2;
	localparam int CTL_POST_A = 3;
	localparam int CTL_POST_B = 4;
	localparam int CTL_TRACE = 5;
	localparam int CTL_CPU_FLAG_A = 8;
	localparam int CTL_DMA_FLAG_A = 9;
	localparam int CTL_CPU_FLAG_B = 10;
	localparam int CTL_DMA_FLAG_B = 11;
	localparam logic [15:0] CTL_CFG_MASK = 16'h003F;
	localparam logic [15:0] CTL_RESET = 16'h0000;
	localparam logic [15:0] SEL_RESET = 16'h0000;
	localparam logic [15:0] COUNT_RESET = 16'h0000;
	localparam logic [15:0] COUNT_LAST = 16'h0001;

	// Operand size codes
	localparam logic [1:0] SZ_ANY = 2'h0;
	localparam logic [1:0] SZ_BYTE = 2'h1;
	localparam logic [1:0] SZ_WORD = 2'h2;
	localparam logic [1:0] SZ_LONG = 2'h3;

	// Break type codes passed to the CPU
	localparam logic [1:0] BT_NONE = 2'h0;
	localparam logic [1:0] BT_FETCH_PRE = 2'h1;
	localparam logic [1:0] BT_FETCH_POST = 2'h2;
	localparam logic [1:0] BT_DATA = 2'h3;

	// Trace entry valid flag position in both trace words
	localparam int TRC_VALID = 31;

	// Bus cycle select register layout
	typedef struct packed {
		logic [6:0] unused;
		logic address_space_id_en;
		logic [1:0] req;
		logic [1:0] kind;
		logic [1:0] rw;
		logic [1:0] size;
	} cycle_sel_s;

	// One observed CPU or DMA data bus cycle
	typedef struct packed {
		logic valid;
		logic is_dma;
		logic is_write;
		logic [1:0] size;
		logic [7:0] address_space_id;
		logic [31:0] addr;
		logic [31:0] data;
	} bus_cycle_s;

	// Instruction entering execution
	typedef struct packed {
		logic valid;
		logic accept;
		logic [7:0] address_space_id;
		logic [31:0] addr;
	} exec_slot_s;

	// Branch record from the pipeline
	typedef struct packed {
		logic valid;
		logic [2:0] decode_buffer_pointer;
		logic [27:0] src;
		logic [27:0] dest;
	} branch_rec_s;
endpackage : break_pkg

// ===== irq_ctrl_model.sv
// Interrupt controller stand-in that accepts break requests
`timescale 1ns/1ps
module irq_ctrl_model (
	input wire logic sys_clk,
	input wire logic rst,
	input wire logic break_req,
	input wire logic [3:0] ack_delay,
	output logic break_ack
);
	logic [3:0] wait_reg;
	// Pulse acceptance once a request has waited ack_delay cycles
	always_ff @(posedge sys_clk or posedge rst) begin
		if (rst) begin
			wait_reg <= 4'h0;
			break_ack <= 1'b0;
		end else if (break_req && !break_ack && wait_reg >= ack_delay) begin
			wait_reg <= 4'h0;
			break_ack <= 1'b1;
		end else begin
			wait_reg <= (break_req && !break_ack) ? wait_reg + 4'h1 : 4'h0;
			break_ack <= 1'b0;
		end
	end
endmodule : irq_ctrl_model

// ===== user_break_unit_tb.sv
// Self-checking bench for the user break unit
`timescale 1ns/1ps
module user_break_unit_tb;
	import break_pkg::*;
	logic sys_clk = 1'b0;
	logic rst = 1'b1;
	logic [7:0] reg_addr = 8'h00;
	logic [31:0] reg_wdata = 32'h0;
	logic reg_wr = 1'b0;
	logic reg_rd = 1'b0;
	logic [31:0] reg_rdata;
	bus_cycle_s bus_cyc = '0;
	exec_slot_s exec_slot = '0;
	branch_rec_s branch_rec = '0;
	logic break_ack;
	logic break_req;
	logic [1:0] break_type;
	logic [31:0] saved_pc;
	logic suppress_exec;
	logic [3:0] ack_dly = 4'h2;
	logic [31:0] ctl = 32'h0;
	logic [31:0] rd;
	int bad_count = 0;
	int checks = 0;

	// Clock and parts
	always #2 sys_clk = ~sys_clk;
	user_break_unit #(.TRACE_DEPTH(8)) dut (.sys_clk(sys_clk), .rst(rst), .reg_addr(reg_addr),
		.reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
		.bus_cyc(bus_cyc), .exec_slot(exec_slot), .branch_rec(branch_rec), .break_ack(break_ack),
		.break_req(break_req), .break_type(break_type), .saved_pc(saved_pc), .suppress_exec(suppress_exec));
	irq_ctrl_model partner (.sys_clk(sys_clk), .rst(rst), .break_req(break_req), .ack_delay(ack_dly),
		.break_ack(break_ack));

	task automatic check(input string name, input logic [31:0] seen, input logic [31:0] exp);
		checks++;
		if (seen !== exp) begin
			bad_count++;
			$display("BAD %s expected %h seen %h", name, exp, seen);
		end
	endtask : check

	// Register port cycles
	task automatic wr(input logic [7:0] a, input logic [31:0] d);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_wdata <= d;
		reg_wr <= 1'b1;
		@(posedge sys_clk);
		reg_wr <= 1'b0;
	endtask : wr

	task automatic rdr(input logic [7:0] a);
		@(posedge sys_clk);
		reg_addr <= a;
		reg_rd <= 1'b1;
		@(posedge sys_clk);
		reg_rd <= 1'b0;
		@(negedge sys_clk);
		rd = reg_rdata;
	endtask : rdr

	// One instruction entering execution
	task automatic slot(input logic [31:0] a, input logic acc, input logic sup);
		@(posedge sys_clk);
		exec_slot <= {1'b1, acc, 8'h00, a};
		@(negedge sys_clk);
		check("suppress_exec", suppress_exec, sup);
		@(posedge sys_clk);
		exec_slot <= '0;
	endtask : slot

	task automatic bus(input logic dma, input logic w, input logic [1:0] sz, input logic [31:0] a,
		input logic [31:0] d);
		@(posedge sys_clk);
		bus_cyc <= {1'b1, dma, w, sz, 8'h00, a, d};
		@(posedge sys_clk);
		bus_cyc <= '0;
	endtask : bus

	// Data cycle with fresh flags, then look at one flag
	task automatic probe(input logic dma, input logic w, input logic [1:0] sz, input logic [31:0] a,
		input logic [31:0] d, input int b, input logic e);
		wr(OFF_CTRL, ctl);
		bus(dma, w, sz, a, d);
		rdr(OFF_CTRL);
		check("match_flag", rd[b], e);
	endtask : probe

	// Bounded wait for a request, judge it, wait for its release
	task automatic brk(input logic [1:0] t, input logic [31:0] pc);
		int n;
		n = 0;
		@(negedge sys_clk);
		while (break_req !== 1'b1 && n < 8) begin
			@(negedge sys_clk);
			n++;
		end
		check("break_req", break_req, 1'b1);
		check("break_type", break_type, t);
		check("saved_pc", saved_pc, pc);
		n = 0;
		while (break_req !== 1'b0 && n < 16) begin
			@(negedge sys_clk);
			n++;
		end
		check("break_release", break_req, 1'b0);
	endtask : brk

	task automatic nobrk();
		repeat (4) @(negedge sys_clk);
		check("no_break", break_req, 1'b0);
	endtask : nobrk

	task automatic scen_fetch();
		wr(OFF_A_ADDR, 32'h0000_0500);
		wr(OFF_A_SEL, 32'h0016);
		slot(32'h0000_0500, 1'b1, 1'b0);
		nobrk();
		wr(OFF_A_SEL, 32'h0056);
		slot(32'h0000_0504, 1'b1, 1'b0);
		slot(32'h0000_0500, 1'b1, 1'b1);
		brk(BT_FETCH_PRE, 32'h0000_0500);
		rdr(OFF_CTRL);
		check("flag_a", rd[CTL_CPU_FLAG_A], 1'b1);
		wr(OFF_CTRL, 32'h0);
		rdr(OFF_CTRL);
		check("flag_a_clear", rd[CTL_CPU_FLAG_A], 1'b0);
		wr(OFF_A_MASK, 32'h0000_000F);
		slot(32'h0000_050C, 1'b1, 1'b1);
		brk(BT_FETCH_PRE, 32'h0000_050C);
		wr(OFF_A_SEL, 32'h0);
		wr(OFF_B_ADDR, 32'h0000_0600);
		wr(OFF_B_DATA, 32'h1234_5678);
		wr(OFF_B_SEL, 32'h0056);
		wr(OFF_CTRL, 32'h2);
		slot(32'h0000_0600, 1'b1, 1'b1);
		brk(BT_FETCH_PRE, 32'h0000_0600);
		rdr(OFF_CTRL);
		check("flag_b", rd[CTL_CPU_FLAG_B], 1'b1);
		slot(32'h0000_0600, 1'b0, 1'b0);
		slot(32'h0000_0602, 1'b1, 1'b1);
		brk(BT_FETCH_PRE, 32'h0000_0602);
		wr(OFF_B_SEL, 32'h0);
	endtask : scen_fetch

	task automatic scen_post();
		wr(OFF_A_MASK, 32'h0);
		wr(OFF_A_ADDR, 32'h0000_0700);
		wr(OFF_A_SEL, 32'h0057);
		wr(OFF_CTRL, 32'h8);
		slot(32'h0000_0700, 1'b1, 1'b0);
		slot(32'h0000_0702, 1'b1, 1'b1);
		brk(BT_FETCH_POST, 32'h0000_0702);
		wr(OFF_A_SEL, 32'h0);
	endtask : scen_post

	task automatic scen_data();
		ctl = 32'h0;
		wr(OFF_A_ADDR, 32'h0000_1003);
		wr(OFF_A_SEL, 32'h0064);
		probe(1'b0, 1'b0, SZ_LONG, 32'h0000_1000, 32'h0, CTL_CPU_FLAG_A, 1'b1);
		probe(1'b0, 1'b0, SZ_WORD, 32'h0000_1002, 32'h0, CTL_CPU_FLAG_A, 1'b1);
		probe(1'b0, 1'b0, SZ_BYTE, 32'h0000_1003, 32'h0, CTL_CPU_FLAG_A, 1'b1);
		probe(1'b0, 1'b0, SZ_BYTE, 32'h0000_1002, 32'h0, CTL_CPU_FLAG_A, 1'b0);
		probe(1'b0, 1'b0, SZ_WORD, 32'h0000_1000, 32'h0, CTL_CPU_FLAG_A, 1'b0);
		slot(32'h0000_2000, 1'b1, 1'b1);
		brk(BT_DATA, 32'h0000_2000);
		nobrk();
		wr(OFF_A_SEL, 32'h0);
		ctl = 32'h2;
		wr(OFF_B_ADDR, 32'h000A_BCDE);
		wr(OFF_B_MASK, 32'h0000_00FF);
		wr(OFF_B_DATA, 32'h0000_A512);
		wr(OFF_B_DMASK, 32'h0000_000F);
		wr(OFF_B_SEL, 32'h006A);
		probe(1'b0, 1'b1, SZ_WORD, 32'h000A_BC10, 32'hFFFF_A51C, CTL_CPU_FLAG_B, 1'b1);
		probe(1'b0, 1'b1, SZ_WORD, 32'h000A_BC10, 32'h0000_A412, CTL_CPU_FLAG_B, 1'b0);
		probe(1'b0, 1'b1, SZ_WORD, 32'h000A_BD10, 32'h0000_A512, CTL_CPU_FLAG_B, 1'b0);
		slot(32'h0000_2100, 1'b1, 1'b1);
		brk(BT_DATA, 32'h0000_2100);
		// DMA byte write with the byte in both halves
		wr(OFF_B_DATA, 32'h0000_7878);
		wr(OFF_B_DMASK, 32'h0000_0F0F);
		wr(OFF_B_ADDR, 32'h0005_5555);
		wr(OFF_B_MASK, 32'h0);
		wr(OFF_B_SEL, 32'h00A9);
		probe(1'b1, 1'b1, SZ_BYTE, 32'h0005_5555, 32'h6363_6363, CTL_DMA_FLAG_B, 1'b0);
		probe(1'b1, 1'b1, SZ_BYTE, 32'h0005_5555, 32'h7373_7373, CTL_DMA_FLAG_B, 1'b1);
		slot(32'h0000_2200, 1'b1, 1'b1);
		brk(BT_DATA, 32'h0000_2200);
		wr(OFF_B_SEL, 32'h0);
	endtask : scen_data

	task automatic scen_seq();
		ack_dly <= 4'h0;
		wr(OFF_A_ADDR, 32'h0000_0100);
		wr(OFF_A_SEL, 32'h0056);
		wr(OFF_B_ADDR, 32'h0000_0200);
		wr(OFF_B_SEL, 32'h0056);
		wr(OFF_CTRL, 32'h4);
		slot(32'h0000_0200, 1'b1, 1'b0);
		slot(32'h0000_0100, 1'b1, 1'b0);
		slot(32'h0000_0200, 1'b1, 1'b1);
		brk(BT_FETCH_PRE, 32'h0000_0200);
		wr(OFF_COUNT, 32'h2);
		wr(OFF_CTRL, 32'h5);
		slot(32'h0000_0100, 1'b1, 1'b0);
		slot(32'h0000_0200, 1'b1, 1'b0);
		slot(32'h0000_0200, 1'b1, 1'b1);
		brk(BT_FETCH_PRE, 32'h0000_0200);
		rdr(OFF_COUNT);
		check("count", rd, {16'h0, COUNT_LAST});
		wr(OFF_A_SEL, 32'h0);
		wr(OFF_B_SEL, 32'h0);
	endtask : scen_seq

	task automatic scen_trace();
		wr(OFF_CTRL, 32'h20);
		for (int i = 1; i <= 3; i++) begin
			@(posedge sys_clk);
			branch_rec <= {1'b1, 3'(i), 28'(32'h100 * i), 28'(32'h900 * i)};
		end
		@(posedge sys_clk);
		branch_rec <= '0;
		rdr(OFF_TSRC);
		check("src1", rd, {1'b1, 3'h1, 28'h000_0100});
		rdr(OFF_TSRC);
		check("src1_read", rd[TRC_VALID], 1'b0);
		rdr(OFF_TDST);
		check("dst1", rd, {1'b1, 3'h0, 28'h000_0900});
		rdr(OFF_TSRC);
		check("src2", rd, {1'b1, 3'h2, 28'h000_0200});
		wr(OFF_CTRL, 32'h0);
		wr(OFF_CTRL, 32'h20);
		rdr(OFF_TDST);
		check("dst2_gone", rd[TRC_VALID], 1'b0);
	endtask : scen_trace

	// Main sequence
	initial begin
		repeat (8) @(posedge sys_clk);
		rst <= 1'b0;
		rdr(OFF_CTRL);
		check("ctrl_reset", rd, {16'h0, CTL_RESET});
		rdr(OFF_A_SEL);
		check("sel_reset", rd, {16'h0, SEL_RESET});
		rdr(OFF_TSRC);
		check("src_reset", rd[TRC_VALID], 1'b0);
		rdr(8'h3C);
		check("unmapped", rd, 32'h0);
		scen_fetch();
		scen_post();
		scen_data();
		scen_seq();
		scen_trace();
		summarize();
	end

	// Watchdog
	initial begin
		#100000;
		bad_count++;
		summarize();
	end

	task automatic summarize();
		$display("Checks %0d mismatches %0d", checks, bad_count);
		if (bad_count == 0 && checks > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask : summarize
endmodule : user_break_unit_tb
